// file: rtl/ir_ambient_pkg.sv
// Constants, register map and state encodings of the infrared ambient configuration block.
package ir_ambient_pkg;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [7:0] OFS_IR_RECOVERY = 8'h1D;
   localparam logic [7:0] OFS_IR_GAIN = 8'h1E;
   localparam logic [7:0] OFS_IR_SIGNAL_RANGE_SELECT = 8'h1F;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h03;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;

   // ==========================================================================
   // Reset values and field positions
   // ==========================================================================
   localparam logic [7:0] RST_IR_RECOVERY = 8'h70;
   localparam logic [7:0] RST_IR_GAIN = 8'h00;
   localparam logic [7:0] RST_IR_SIGNAL_RANGE_SELECT = 8'h00;
   localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
   localparam logic [7:0] MASK_IR_RECOVERY = 8'h70;
   localparam int RECOVERY_LSB = 4;
   localparam int GAIN_LSB = 0;
   localparam int RANGE_BIT = 5;
   localparam int IRQ_EN_BIT = 0;
   localparam int IRQ_PEND_BIT = 0;
   localparam int LOW_POWER_BIT = 1;

   // ==========================================================================
   // Sequencer revision and timing
   // ==========================================================================
   localparam logic [7:0] SEQ_REV_MIN = 8'h03;
   localparam int SYS_CLK_MHZ = 125;
   localparam int ADC_CLK_NS = 50;
   localparam int ADC_CLK_CYC_INT = (ADC_CLK_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [9:0] ADC_CLK_CYC = 10'(ADC_CLK_CYC_INT);
   localparam logic [9:0] INTEG_ADC_CLKS = 10'h010;

   // ==========================================================================
   // Conversion sequencer states, Gray along idle, recover, integrate
   // ==========================================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RECOVER = 2'h1,
      ST_INTEG = 2'h3
   } conv_state_e;

endpackage : ir_ambient_pkg

// file: rtl/ir_conv_if.sv
// Interface between the register front end and the conversion timer.
`timescale 1ns/1ps
interface ir_conv_if;
   logic start;
   logic [2:0] gain;
   logic [2:0] rec_sel;
   logic adc_tick;
   logic recovering;
   logic integrating;
   logic done;

   modport ctl (output start, output gain, output rec_sel,
                input adc_tick, input recovering, input integrating, input done);
   modport tmr (input start, input gain, input rec_sel,
                output adc_tick, output recovering, output integrating, output done);
endinterface : ir_conv_if

// file: rtl/ir_conv_timer.sv
// Conversion timer: divided ADC clock, recovery wait and integration window.
`timescale 1ns/1ps
module ir_conv_timer (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Link to the register front end.
   ir_conv_if.tmr c
);
   import ir_ambient_pkg::*;

   conv_state_e state, next_state;
   logic [9:0] cnt, next_cnt;
   logic [9:0] ticks, next_ticks;
   logic [2:0] gain_q, next_gain_q;
   logic [2:0] rec_q, next_rec_q;
   logic next_tick, next_done;
   logic [9:0] period;
   logic [9:0] target;
   logic [9:0] rec_len;

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   // Gain and recovery are latched at start so a mid-conversion write cannot skew one window.
   always_comb begin
      period = 10'(ADC_CLK_CYC << gain_q);
      rec_len = (rec_q == 3'h0) ? 10'h001 : 10'((10'h004 << rec_q) - 10'h001);
      target = (state == ST_RECOVER) ? rec_len : INTEG_ADC_CLKS;
      next_state = state;
      next_cnt = cnt;
      next_ticks = ticks;
      next_gain_q = gain_q;
      next_rec_q = rec_q;
      next_tick = 1'b0;
      next_done = 1'b0;
      case (state)
         ST_IDLE: begin
            if (c.start) begin
               next_gain_q = c.gain;
               next_rec_q = c.rec_sel;
               next_cnt = 10'h000;
               next_ticks = 10'h000;
               next_state = ST_RECOVER;
            end
         end
         default: begin
            if (cnt == period - 10'h001) begin
               next_cnt = 10'h000;
               next_tick = 1'b1;
               if (ticks + 10'h001 == target) begin
                  next_ticks = 10'h000;
                  if (state == ST_RECOVER) begin
                     next_state = ST_INTEG;
                  end else begin
                     next_state = ST_IDLE;
                     next_done = 1'b1;
                  end
               end else begin
                  next_ticks = ticks + 10'h001;
               end
            end else begin
               next_cnt = cnt + 10'h001;
            end
         end
      endcase
   end

   // Registers of the sequencer; all outputs come from here.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= ST_IDLE;
         cnt <= 10'h000;
         ticks <= 10'h000;
         gain_q <= 3'h0;
         rec_q <= 3'h0;
         c.adc_tick <= 1'b0;
         c.done <= 1'b0;
         c.recovering <= 1'b0;
         c.integrating <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ticks <= next_ticks;
         gain_q <= next_gain_q;
         rec_q <= next_rec_q;
         c.adc_tick <= next_tick;
         c.done <= next_done;
         c.recovering <= (next_state == ST_RECOVER);
         c.integrating <= (next_state == ST_INTEG);
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   logic [9:0] gap;
   logic gap_valid;
   logic [9:0] rec_seen;

   // Helper: cycles since last tick and ticks seen before integration.
   always_ff @(posedge sys_clk) begin
      if (!rstn || (state == ST_IDLE && c.start)) begin
         gap <= 10'h000;
         gap_valid <= 1'b0;
         rec_seen <= 10'h000;
      end else begin
         gap <= c.adc_tick ? 10'h001 : gap + 10'h001;
         gap_valid <= gap_valid | c.adc_tick;
         rec_seen <= rec_seen + ((c.adc_tick && !c.integrating) ? 10'h001 : 10'h000);
      end
   end

   property p_tick_period;
      @(posedge sys_clk) disable iff (!rstn)
      (c.adc_tick && gap_valid) |-> (gap == 10'(ADC_CLK_CYC << gain_q));
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("ADC tick spacing wrong for gain.");

   property p_div16;
      @(posedge sys_clk) disable iff (!rstn)
      (c.adc_tick && gap_valid && gain_q == 3'h4) |-> (gap == 10'(ADC_CLK_CYC * 16));
   endproperty
   a_div16: assert property (p_div16) else $error("Gain 4 does not divide by 16.");

   property p_recovery;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(c.integrating) |-> (rec_seen + 10'h001 == rec_len);
   endproperty
   a_recovery: assert property (p_recovery) else $error("Recovery length mismatch.");

   c_conv_done: cover property (@(posedge sys_clk) disable iff (!rstn) c.done);
endmodule : ir_conv_timer

// file: rtl/ir_ambient_cfg.sv
// Infrared ambient configuration registers, conversion control and interrupt pin.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module ir_ambient_cfg #(
   parameter logic [7:0] SEQ_REV = ir_ambient_pkg::SEQ_REV_MIN
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Measurement path.
   input wire logic conv_start,
   output logic adc_tick,
   output logic recovering,
   output logic integrating,
   output logic conv_done,
   output logic ir_signal_range_select,
   // Open-drain interrupt pin.
   input wire logic int_in,
   output logic int_out,
   output logic int_oe,
   output logic low_power_mode
);
   import ir_ambient_pkg::*;

   localparam logic REV_OK = (SEQ_REV >= SEQ_REV_MIN);

   ir_conv_if conv ();

   ir_conv_timer u_timer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .c(conv.tmr)
   );

   logic [7:0] ir_integration_scale, next_ir_integration_scale;
   logic [7:0] ir_signal_range_select_param, next_ir_signal_range_select_param;
   logic [7:0] ir_recovery_param, next_ir_recovery_param;
   logic irq_en, next_irq_en;
   logic irq_pend, next_irq_pend;
   logic next_range_sel;
   logic [7:0] next_rdata;
   logic [2:0] gain_eff, next_gain_eff;
   logic lp_caught, next_lp_caught;
   logic next_low_power;
   logic wr_gain, wr_range;

   // ==========================================================================
   // Register writes and derived settings
   // ==========================================================================
   // Derived settings follow the next register values so they track a write in one cycle.
   always_comb begin
      wr_gain = reg_wr && (reg_addr == OFS_IR_GAIN);
      wr_range = reg_wr && (reg_addr == OFS_IR_SIGNAL_RANGE_SELECT);
      next_ir_integration_scale = ir_integration_scale;
      next_ir_signal_range_select_param = ir_signal_range_select_param;
      next_ir_recovery_param = ir_recovery_param;
      next_irq_en = irq_en;
      if (wr_gain) begin
         next_ir_integration_scale = reg_wdata;
      end else if (wr_range) begin
         // Reserved bits are stored as written; the host keeps them intact.
         next_ir_signal_range_select_param = reg_wdata;
      end else if (reg_wr && reg_addr == OFS_IR_RECOVERY) begin
         next_ir_recovery_param = reg_wdata & MASK_IR_RECOVERY;
      end else if (reg_wr && reg_addr == OFS_IRQ_CTRL) begin
         next_irq_en = reg_wdata[IRQ_EN_BIT];
      end
      // Only bits 2:0 steer the divider; older sequencers see no scaling.
      next_gain_eff = REV_OK ? next_ir_integration_scale[GAIN_LSB +: 3] : 3'h0;
      next_range_sel = REV_OK && next_ir_signal_range_select_param[RANGE_BIT];
   end

   // Register bank state.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ir_integration_scale <= RST_IR_GAIN;
         ir_signal_range_select_param <= RST_IR_SIGNAL_RANGE_SELECT;
         ir_recovery_param <= RST_IR_RECOVERY;
         irq_en <= RST_IRQ_CTRL[IRQ_EN_BIT];
         gain_eff <= 3'h0;
         ir_signal_range_select <= 1'b0;
      end else begin
         ir_integration_scale <= next_ir_integration_scale;
         ir_signal_range_select_param <= next_ir_signal_range_select_param;
         ir_recovery_param <= next_ir_recovery_param;
         irq_en <= next_irq_en;
         gain_eff <= next_gain_eff;
         ir_signal_range_select <= next_range_sel;
      end
   end

   // Timer control; a start while a conversion runs is ignored by the timer.
   assign conv.start = conv_start;
   assign conv.gain = gain_eff;
   assign conv.rec_sel = ir_recovery_param[RECOVERY_LSB +: 3];

   // ==========================================================================
   // Read port, interrupt pin and power-up strap
   // ==========================================================================
   // Read data stand for one cycle only; unmapped reads return zero.
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == OFS_IR_GAIN) begin
            next_rdata = ir_integration_scale;
         end else if (reg_addr == OFS_IR_SIGNAL_RANGE_SELECT) begin
            next_rdata = ir_signal_range_select_param;
         end else if (reg_addr == OFS_IR_RECOVERY) begin
            next_rdata = ir_recovery_param;
         end else if (reg_addr == OFS_IRQ_CTRL) begin
            next_rdata[IRQ_EN_BIT] = irq_en;
         end else if (reg_addr == OFS_IRQ_STATUS) begin
            next_rdata[IRQ_PEND_BIT] = irq_pend;
            next_rdata[LOW_POWER_BIT] = low_power_mode;
         end
      end
      // A finishing conversion beats a same-cycle write-one clear when irq_en is set.
      next_irq_pend = irq_pend;
      if (reg_wr && reg_addr == OFS_IRQ_STATUS && reg_wdata[IRQ_PEND_BIT]) begin
         next_irq_pend = 1'b0;
      end
      if (conv.done && irq_en) begin
         next_irq_pend = 1'b1;
      end
      // The pin level is caught once, in the first cycle after reset release.
      next_lp_caught = 1'b1;
      next_low_power = lp_caught ? low_power_mode : int_in;
   end

   // Output and status flops; the pin is only ever pulled low.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
         irq_pend <= 1'b0;
         int_out <= 1'b0;
         int_oe <= 1'b0;
         lp_caught <= 1'b0;
         low_power_mode <= 1'b0;
         adc_tick <= 1'b0;
         recovering <= 1'b0;
         integrating <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         irq_pend <= next_irq_pend;
         int_out <= 1'b0;
         int_oe <= next_irq_pend;
         lp_caught <= next_lp_caught;
         low_power_mode <= next_low_power;
         adc_tick <= conv.adc_tick;
         recovering <= conv.recovering;
         integrating <= conv.integrating;
         conv_done <= conv.done;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   property p_range_sel;
      @(posedge sys_clk) disable iff (!rstn)
      wr_range |=> (ir_signal_range_select == (REV_OK && $past(reg_wdata[RANGE_BIT])));
   endproperty
   a_range_sel: assert property (p_range_sel) else $error("Range select does not follow bit 5.");

   property p_reset_zero;
      @(posedge sys_clk)
      !rstn |=> (ir_integration_scale == 8'h00 && ir_signal_range_select_param == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("Gain or range not zero after reset.");

   property p_old_rev;
      @(posedge sys_clk) disable iff (!rstn)
      !REV_OK |-> (gain_eff == 3'h0 && !ir_signal_range_select);
   endproperty
   a_old_rev: assert property (p_old_rev) else $error("Settings active on old revision.");

   property p_int_low_only;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(int_oe) |-> (!int_out && $past(conv.done) && $past(irq_en));
   endproperty
   a_int_low_only: assert property (p_int_low_only) else $error("Interrupt pin driven without cause.");

   property p_gain_ignore_high;
      @(posedge sys_clk) disable iff (!rstn)
      wr_gain |=> (gain_eff == (REV_OK ? $past(reg_wdata[2:0]) : 3'h0));
   endproperty
   a_gain_ignore_high: assert property (p_gain_ignore_high) else $error("Gain uses reserved bits.");

   // A clear with no finishing conversion in the same cycle must let the wire go.
   property p_irq_clear;
      @(posedge sys_clk) disable iff (!rstn)
      (reg_wr && reg_addr == OFS_IRQ_STATUS && reg_wdata[IRQ_PEND_BIT] && !conv.done) |=> !int_oe;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("Pin not released on clear.");

   // Without a clear the pin keeps pulling low, so a slow host cannot miss the event.
   property p_irq_hold;
      @(posedge sys_clk) disable iff (!rstn)
      (int_oe && !(reg_wr && reg_addr == OFS_IRQ_STATUS && reg_wdata[IRQ_PEND_BIT])) |=> int_oe;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("Pin released without clear.");

   // Once caught, the power-up level must ignore later activity on the wire, our own pulls included.
   property p_low_power_hold;
      @(posedge sys_clk) disable iff (!rstn)
      lp_caught |=> $stable(low_power_mode);
   endproperty
   a_low_power_hold: assert property (p_low_power_hold) else $error("Power-up level moved.");

   c_low_power: cover property (@(posedge sys_clk) disable iff (!rstn) low_power_mode && int_oe);
   c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(int_oe));
   c_high_range: cover property (@(posedge sys_clk) disable iff (!rstn) ir_signal_range_select && conv_done);
   c_b2b_wr: cover property (@(posedge sys_clk) disable iff (!rstn) wr_gain ##1 wr_range);
endmodule : ir_ambient_cfg

// file: tb/ir_host_model.sv
// Host-side model of the open-drain interrupt wire and its pull-up.
`timescale 1ns/1ps
module ir_host_model (
   // Pin control from the device.
   input wire logic int_oe,
   // Resolved wire level fed back to the device.
   output logic int_in
);
   // ==========================================================================
   // Wire resolution
   // ==========================================================================
   // The host side only has a pull-up, so the wire reads high whenever the device lets go.
   // An unknown enable also counts as released, which keeps the wire high through power-up.
   always_comb begin
      int_in = (int_oe === 1'b1) ? 1'b0 : 1'b1;
   end
endmodule : ir_host_model

// file: tb/testbench.sv
// Self-checking testbench of the infrared ambient configuration block.
`timescale 1ns/1ps
module testbench;
   import ir_ambient_pkg::*;
   // ==========================================================================
   // Signals and bookkeeping
   // ==========================================================================
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic conv_start = 1'b0;
   logic [7:0] reg_rdata;
   logic adc_tick, recovering, integrating, conv_done, ir_signal_range_select;
   logic int_in, int_out, int_oe, low_power_mode, old_range;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   logic [7:0] rd_val;
   logic [7:0] shadow_range = 8'h00;
   logic [31:0] seed_val;
   logic [2:0] gains[5] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h2};
   logic [2:0] recs[5] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h7};
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;

   // Clock at 125 MHz.
   always #4 sys_clk = ~sys_clk;

   // ==========================================================================
   // Design, an older-revision copy and the host model
   // ==========================================================================
   ir_ambient_cfg ir_ambient_cfg_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .conv_start(conv_start), .adc_tick(adc_tick), .recovering(recovering),
      .integrating(integrating), .conv_done(conv_done), .ir_signal_range_select(ir_signal_range_select),
      .int_in(int_in), .int_out(int_out), .int_oe(int_oe), .low_power_mode(low_power_mode));
   ir_ambient_cfg #(.SEQ_REV(8'h02)) old_rev_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
      .conv_start(conv_start), .adc_tick(), .recovering(), .integrating(), .conv_done(),
      .ir_signal_range_select(old_range), .int_in(1'b1), .int_out(), .int_oe(), .low_power_mode());
   ir_host_model ir_host_model_inst (.int_oe(int_oe), .int_in(int_in));

   // ==========================================================================
   // Checking and closing
   // ==========================================================================
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask : compare

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // Read data stand only in the cycle after the strobe, so the oldest note is taken then.
   always @(posedge sys_clk) begin
      if (rd_seen) begin
         compare(32'(reg_rdata), 32'(exp_q.pop_front()));
      end
      rd_seen <= reg_rd;
   end

   // A hang is cut short well above the roughly 40000 cycles the tests need.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 70000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ==========================================================================
   // Bus and sequence tasks
   // ==========================================================================
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, output logic [7:0] got);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(exp);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      got = reg_rdata;
   endtask : rd

   // Reserved bits are carried over from a fresh read, never written blind.
   task automatic set_range(input logic sel);
      logic [7:0] cur;
      rd(OFS_IR_SIGNAL_RANGE_SELECT, shadow_range, cur);
      shadow_range = (cur & 8'hDF) | {2'b00, sel, 5'h00};
      wr(OFS_IR_SIGNAL_RANGE_SELECT, shadow_range);
      @(posedge sys_clk);
      #1;
      compare(32'(ir_signal_range_select), 32'(sel));
      compare(32'(old_range), 32'h0);
   endtask : set_range

   // One conversion; recovery, integration and tick spacing are measured in clock cycles.
   task automatic run_conv(input logic [2:0] gain, input logic [2:0] rec);
      logic [31:0] p, r, rec_cyc, int_cyc, last_tick, period;
      int n;
      p = 32'(ADC_CLK_CYC_INT) << gain;
      r = (rec == 3'h0) ? 32'd1 : (32'd4 << rec) - 32'd1;
      rec_cyc = 0;
      int_cyc = 0;
      last_tick = 0;
      period = 0;
      wr(OFS_IR_GAIN, {5'($urandom), gain});
      wr(OFS_IR_RECOVERY, {1'b0, rec, 4'h0});
      @(posedge sys_clk);
      conv_start <= 1'b1;
      @(posedge sys_clk);
      conv_start <= 1'b0;
      for (n = 0; n < 20000 && conv_done !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
         if (recovering === 1'b1) rec_cyc++;
         if (integrating === 1'b1) int_cyc++;
         if (adc_tick === 1'b1) begin
            period = n - last_tick;
            last_tick = n;
         end
      end
      compare(32'(conv_done), 32'h1);
      compare(period, p);
      compare(int_cyc, 32'(INTEG_ADC_CLKS) * p);
      compare(rec_cyc, r * p);
      $display("test conversion gain %0d recovery %0d done", gain, rec);
   endtask : run_conv

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      seed_val = $urandom(77955);
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(OFS_IR_GAIN, 8'h00, rd_val);
      rd(OFS_IR_SIGNAL_RANGE_SELECT, 8'h00, rd_val);
      rd(OFS_IR_RECOVERY, 8'h70, rd_val);
      rd(8'h55, 8'h00, rd_val);
      rd(OFS_IRQ_STATUS, 8'h02, rd_val);
      compare(32'(low_power_mode), 32'h1);
      compare(32'(int_oe), 32'h0);
      $display("test reset values done");
      set_range(1'b1);
      rd(OFS_IR_SIGNAL_RANGE_SELECT, 8'h20, rd_val);
      // High range stays selected through the conversions, so it is also seen beside a finished one.
      wr(OFS_IRQ_CTRL, 8'h01);
      for (int i = 0; i < 5; i++) begin
         run_conv(gains[i], recs[i]);
      end
      set_range(1'b0);
      $display("test range select done");
      repeat (2) @(posedge sys_clk);
      #1;
      compare(32'(int_oe), 32'h1);
      compare(32'(int_out), 32'h0);
      compare(32'(int_in), 32'h0);
      rd(OFS_IRQ_STATUS, 8'h03, rd_val);
      wr(OFS_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1;
      compare(32'(int_oe), 32'h0);
      compare(32'(int_in), 32'h1);
      $display("test interrupt pin done");
      // A reset in mid-run must wipe settings that differ from zero, gain upper bits included.
      set_range(1'b1);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(OFS_IR_GAIN, 8'h00, rd_val);
      rd(OFS_IR_SIGNAL_RANGE_SELECT, 8'h00, rd_val);
      compare(32'(ir_signal_range_select), 32'h0);
      $display("test reset in mid-run done");
      tally_and_finish();
   end
endmodule : testbench
